// ### rtl/diagnostic_record_bank.sv
// Read-only diagnostic record of a two-channel analog input module
`timescale 1ns/1ps
`include "diag_record_cfg.svh"

module diagnostic_record_bank
   import diag_record_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter int CYCLES_PER_US = `DR_CYCLES_PER_US
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input diag_record_pkg::module_fault_s mod_fault_i,
   input diag_record_pkg::channel_fault_s [NUM_CH-1:0] ch_fault_i,
   input diag_record_pkg::record_req_s req_i,
   output diag_record_pkg::record_rsp_s rsp_o,
   output logic [7:0] module_fault_flags_o,
   output logic [31:0] fault_time_stamp_o
);

   import diag_record_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Fault sources come from pins of the analog front end
   module_fault_s mod_s1_ff;
   module_fault_s mod_s2_ff;
   channel_fault_s [NUM_CH-1:0] ch_s1_ff;
   channel_fault_s [NUM_CH-1:0] ch_s2_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mod_s1_ff <= '0;
         mod_s2_ff <= '0;
         ch_s1_ff <= '0;
         ch_s2_ff <= '0;
      end else begin
         mod_s1_ff <= mod_fault_i;
         mod_s2_ff <= mod_s1_ff;
         ch_s1_ff <= ch_fault_i;
         ch_s2_ff <= ch_s1_ff;
      end
   end

   // ---------------------------------------------------------------
   // Microsecond ticker
   // ---------------------------------------------------------------
   wire logic [31:0] us_now;

   us_ticker #(
      .CYCLES_PER_US(CYCLES_PER_US)
   ) u_ticker (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .us_count_o(us_now)
   );

   // ---------------------------------------------------------------
   // Channel fault bytes
   // ---------------------------------------------------------------
   wire logic [7:0] ch_byte [NUM_CH];
   wire logic [NUM_CH-1:0] ch_any;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         wire logic [7:0] b;
         assign b[`DR_CF_PARAM] = ch_s2_ff[gi].param_err;
         assign b[3:1] = 3'h0;
         assign b[`DR_CF_WIRE_BREAK] = ch_s2_ff[gi].wire_break;
         assign b[`DR_CF_IRQ_LOST] = ch_s2_ff[gi].irq_lost;
         assign b[`DR_CF_UNDERFLOW] = ch_s2_ff[gi].underflow;
         assign b[`DR_CF_OVERFLOW] = ch_s2_ff[gi].overflow;
         assign ch_byte[gi] = b;
         assign ch_any[gi] = |b;
      end
   endgenerate

   // Each channel forms its own group; groups beyond bit 1 read zero
   wire logic [7:0] grp_byte;
   assign grp_byte = {{(8 - NUM_CH){1'b0}}, ch_any};

   // ---------------------------------------------------------------
   // Module level flag bytes
   // ---------------------------------------------------------------
   wire logic [7:0] mod_byte;
   wire logic [7:0] ext_byte;
   wire logic [7:0] class_byte;

   assign mod_byte[`DR_MF_FAILED] = mod_s2_ff.failed;
   assign mod_byte[`DR_MF_INTERNAL] = mod_s2_ff.internal_err;
   assign mod_byte[`DR_MF_EXTERNAL] = mod_s2_ff.external_err;
   assign mod_byte[`DR_MF_CHANNEL] = |ch_any;
   assign mod_byte[`DR_MF_AUX_MISSING] = mod_s2_ff.aux_missing;
   assign mod_byte[6:5] = 2'h0;
   assign mod_byte[`DR_MF_PARAM] = mod_s2_ff.param_err;

   assign ext_byte[2:0] = 3'h0;
   assign ext_byte[`DR_EF_BUF_OVF] = mod_s2_ff.buf_overflow;
   assign ext_byte[`DR_EF_COMM] = mod_s2_ff.comm_err;
   assign ext_byte[5] = 1'b0;
   assign ext_byte[`DR_EF_IRQ_LOST] = mod_s2_ff.irq_lost;
   assign ext_byte[7] = 1'b0;

   assign class_byte = {3'h0, `DR_CLASS_CH_INFO, `DR_CLASS_ANALOG};

   // ---------------------------------------------------------------
   // Time stamp capture
   // ---------------------------------------------------------------
   // The stamp is taken when any fault flag first rises, so it
   // tells when the diagnosis came in rather than when it was read.
   logic [31:0] stamp_ff;
   logic any_prev_ff;
   wire logic any_fault;
   wire logic fault_rise;

   assign any_fault = (|mod_byte) | (|ext_byte);
   assign fault_rise = any_fault & ~any_prev_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stamp_ff <= `DR_ZERO_WORD;
         any_prev_ff <= 1'b0;
      end else begin
         any_prev_ff <= any_fault;
         if (fault_rise) begin
            stamp_ff <= us_now;
         end
      end
   end

   // ---------------------------------------------------------------
   // Subindex decode
   // ---------------------------------------------------------------
   wire logic idx_hit;
   wire logic sx_unused;
   wire logic sx_known;
   wire logic [7:0] sx;

   assign sx = req_i.object_subindex;
   assign idx_hit = (req_i.object_index == `DR_OBJECT_INDEX);
   assign sx_unused = (sx >= `DR_SX_UNUSED_LO) && (sx <= `DR_SX_UNUSED_HI);
   assign sx_known = (sx >= `DR_SX_MOD_FAULT) && (sx <= `DR_SX_UNUSED_HI) || (sx == `DR_SX_TIME_STAMP);

   // Read data mux; reserved and unmapped subindices answer zero
   logic [31:0] rd_data;
   always_comb begin
      rd_data = `DR_ZERO_WORD;
      unique case (sx)
         `DR_SX_MOD_FAULT: rd_data = {24'h0, mod_byte};
         `DR_SX_MOD_CLASS: rd_data = {24'h0, class_byte};
         `DR_SX_RSVD_A: rd_data = `DR_ZERO_WORD;
         `DR_SX_EXT_FAULT: rd_data = {24'h0, ext_byte};
         `DR_SX_CH_KIND: rd_data = {25'h0, `DR_CH_KIND_AI};
         `DR_SX_DIAG_BITS: rd_data = {24'h0, `DR_DIAG_BITS};
         `DR_SX_CH_COUNT: rd_data = {24'h0, `DR_CH_COUNT};
         `DR_SX_GRP_FAULT: rd_data = {24'h0, grp_byte};
         `DR_SX_CH0_FAULT: rd_data = {24'h0, ch_byte[0]};
         `DR_SX_CH1_FAULT: rd_data = {24'h0, ch_byte[1]};
         `DR_SX_TIME_STAMP: rd_data = stamp_ff;
         default: rd_data = `DR_ZERO_WORD;
      endcase
   end

   // ---------------------------------------------------------------
   // Answer register
   // ---------------------------------------------------------------
   // Writes are answered with hit low and zero data and change nothing in the record
   record_rsp_s rsp_ff;
   logic [7:0] mod_out_ff;
   logic [31:0] stamp_out_ff;
   wire logic rd_ok;

   assign rd_ok = idx_hit & sx_known & ~req_i.write;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rsp_ff <= '0;
         mod_out_ff <= `DR_ZERO_BYTE;
         stamp_out_ff <= `DR_ZERO_WORD;
      end else begin
         rsp_ff.valid <= req_i.valid;
         rsp_ff.hit <= req_i.valid & rd_ok;
         rsp_ff.data <= (req_i.valid & rd_ok) ? rd_data : `DR_ZERO_WORD;
         mod_out_ff <= mod_byte;
         stamp_out_ff <= stamp_ff;
      end
   end

   assign rsp_o = rsp_ff;
   assign module_fault_flags_o = mod_out_ff;
   assign fault_time_stamp_o = stamp_out_ff;

endmodule : diagnostic_record_bank

// ### include/diag_record_cfg.svh
// Offsets, field positions, reset values and timing counts of the diagnostic record
`ifndef DIAG_RECORD_CFG_SVH
`define DIAG_RECORD_CFG_SVH

// ---------------------------------------------------------------
// Object addressing
// ---------------------------------------------------------------
`define DR_OBJECT_INDEX 16'h5005
`define DR_SX_MOD_FAULT 8'h02
`define DR_SX_MOD_CLASS 8'h03
`define DR_SX_RSVD_A 8'h04
`define DR_SX_EXT_FAULT 8'h05
`define DR_SX_CH_KIND 8'h06
`define DR_SX_DIAG_BITS 8'h07
`define DR_SX_CH_COUNT 8'h08
`define DR_SX_GRP_FAULT 8'h09
`define DR_SX_CH0_FAULT 8'h0A
`define DR_SX_CH1_FAULT 8'h0B
`define DR_SX_UNUSED_LO 8'h0C
`define DR_SX_UNUSED_HI 8'h11
`define DR_SX_TIME_STAMP 8'h13

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DR_MF_FAILED 0
`define DR_MF_INTERNAL 1
`define DR_MF_EXTERNAL 2
`define DR_MF_CHANNEL 3
`define DR_MF_AUX_MISSING 4
`define DR_MF_PARAM 7
`define DR_EF_BUF_OVF 3
`define DR_EF_COMM 4
`define DR_EF_IRQ_LOST 6
`define DR_CF_PARAM 0
`define DR_CF_WIRE_BREAK 4
`define DR_CF_IRQ_LOST 5
`define DR_CF_UNDERFLOW 6
`define DR_CF_OVERFLOW 7

// ---------------------------------------------------------------
// Fixed values
// ---------------------------------------------------------------
`define DR_CLASS_ANALOG 4'h5
`define DR_CLASS_CH_INFO 1'h1
`define DR_CH_KIND_AI 7'h71
`define DR_DIAG_BITS 8'h08
`define DR_CH_COUNT 8'h02
`define DR_ZERO_BYTE 8'h00
`define DR_ZERO_WORD 32'h0000_0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DR_CLK_MHZ 200
`define DR_US_NS 1000
`define DR_CLK_NS 5
`define DR_CYCLES_PER_US (`DR_US_NS / `DR_CLK_NS)

`endif

// ### include/diag_record_pkg.sv
// Types shared by the diagnostic record bank
package diag_record_pkg;

   // ---------------------------------------------------------------
   // Fault inputs of one analog channel
   // ---------------------------------------------------------------
   typedef struct packed {
      logic param_err;
      logic wire_break;
      logic irq_lost;
      logic underflow;
      logic overflow;
   } channel_fault_s;

   // ---------------------------------------------------------------
   // Module-level fault inputs
   // ---------------------------------------------------------------
   typedef struct packed {
      logic failed;
      logic internal_err;
      logic external_err;
      logic aux_missing;
      logic param_err;
      logic buf_overflow;
      logic comm_err;
      logic irq_lost;
   } module_fault_s;

   // ---------------------------------------------------------------
   // Read request and answer
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] object_index;
      logic [7:0] object_subindex;
   } record_req_s;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [31:0] data;
   } record_rsp_s;

endpackage : diag_record_pkg

// ### rtl/us_ticker.sv
// Free running 32-bit microsecond counter
`timescale 1ns/1ps
`include "diag_record_cfg.svh"

module us_ticker #(
   parameter int CYCLES_PER_US = `DR_CYCLES_PER_US
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   output logic [31:0] us_count_o
);

   localparam int PW = $clog2(CYCLES_PER_US);

   logic [PW-1:0] pre_ff;
   logic [31:0] us_ff;
   wire logic us_tick;

   // ---------------------------------------------------------------
   // Prescaler and counter
   // ---------------------------------------------------------------
   assign us_tick = (pre_ff == PW'(CYCLES_PER_US - 1));

   // Plain 32-bit add wraps to zero after the maximum on its own
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pre_ff <= '0;
         us_ff <= `DR_ZERO_WORD;
      end else begin
         pre_ff <= us_tick ? '0 : PW'(pre_ff + 1'b1);
         if (us_tick) begin
            us_ff <= us_ff + 32'h0000_0001;
         end
      end
   end

   assign us_count_o = us_ff;

endmodule : us_ticker

// ### tb/diag_record_checker.sv
// Port assertions of the diagnostic record bank
`timescale 1ns/1ps
`include "diag_record_cfg.svh"
module diag_record_checker
   import diag_record_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter int CYCLES_PER_US = `DR_CYCLES_PER_US
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input diag_record_pkg::module_fault_s mod_fault_i,
   input diag_record_pkg::channel_fault_s [NUM_CH-1:0] ch_fault_i,
   input diag_record_pkg::record_req_s req_i,
   input diag_record_pkg::record_rsp_s rsp_o,
   input logic [7:0] module_fault_flags_o,
   input logic [31:0] fault_time_stamp_o
);
   import diag_record_pkg::*;
   logic [2:0] up_ff;
   // The failure, supply and channel flag checks wait until the input synchronisers have refilled after reset
   wire warm = up_ff == 3'h7;
   wire ok_rd = req_i.valid && !req_i.write && req_i.object_index == `DR_OBJECT_INDEX;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) up_ff <= 3'h0;
      else if (!warm) up_ff <= up_ff + 3'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   rsp_next_a: assert property (req_i.valid |=> rsp_o.valid) else $error("request not answered");
   rsp_quiet_a: assert property (!req_i.valid |=> !rsp_o.valid) else $error("answer without request");
   refuse_zero_a: assert property (req_i.valid && !ok_rd |=> !rsp_o.hit && rsp_o.data == 32'h0)
      else $error("refused access returned data");
   class_byte_a: assert property (ok_rd && req_i.object_subindex == 8'h03 |=> rsp_o.data == 32'h15)
      else $error("module class byte wrong");
   count_byte_a: assert property (ok_rd && req_i.object_subindex == 8'h08 |=> rsp_o.data == 32'h2)
      else $error("channel count wrong");
   kind_byte_a: assert property (ok_rd && req_i.object_subindex == 8'h06 |=> rsp_o.data == 32'h71)
      else $error("channel type wrong");
   flag_rsvd_a: assert property (module_fault_flags_o[6:5] == 2'b00) else $error("reserved flags set");
   fail_flag_a: assert property ((warm && $stable(mod_fault_i.failed)) [*4]
      |-> module_fault_flags_o[0] == mod_fault_i.failed) else $error("failure flag wrong");
   aux_flag_a: assert property ((warm && $stable(mod_fault_i.aux_missing)) [*4]
      |-> module_fault_flags_o[4] == mod_fault_i.aux_missing) else $error("supply flag wrong");
   chan_flag_a: assert property ((warm && ch_fault_i[0].wire_break) [*5] |-> module_fault_flags_o[3])
      else $error("channel flag missing");
endmodule : diag_record_checker
bind diagnostic_record_bank diag_record_checker #(.NUM_CH(NUM_CH), .CYCLES_PER_US(CYCLES_PER_US))
   diag_record_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .mod_fault_i(mod_fault_i), .ch_fault_i(ch_fault_i),
   .req_i(req_i), .rsp_o(rsp_o), .module_fault_flags_o(module_fault_flags_o), .fault_time_stamp_o(fault_time_stamp_o));

// ### tb/coupler_model.sv
// Behavioural bus coupler that reads the diagnostic record
`timescale 1ns/1ps
module coupler_model
   import diag_record_pkg::*;
(
   input wire logic clk_i,
   output diag_record_pkg::record_req_s req_o,
   input diag_record_pkg::record_rsp_s rsp_i
);
   import diag_record_pkg::*;
   initial req_o = '0;
   // One-cycle request on a falling edge; the answer is polled a bounded number of cycles
   task automatic access(input logic wr, input logic [15:0] ix, input logic [7:0] sx,
      output logic [31:0] data, output logic hit, output logic late);
      late = 1'b1;
      data = '0;
      hit = 1'b0;
      @(negedge clk_i);
      req_o = '{valid: 1'b1, write: wr, object_index: ix, object_subindex: sx};
      @(negedge clk_i);
      // Idle fields show a changed pattern so a stale address cannot pass
      req_o = '{valid: 1'b0, write: ~wr, object_index: ~ix, object_subindex: ~sx};
      for (int n = 0; n < 3 && late; n++) begin
         if (rsp_i.valid === 1'b1) begin
            data = rsp_i.data;
            hit = rsp_i.hit;
            late = 1'b0;
         end else @(negedge clk_i);
      end
   endtask : access
endmodule : coupler_model

// ### tb/diagnostic_record_bank_bench.sv
// Self-checking bench of the diagnostic record bank
`timescale 1ns/1ps
`include "diag_record_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module diagnostic_record_bank_bench;
   import diag_record_pkg::*;
   localparam int CPU = 4;
   localparam logic [63:0] MTAB = 64'h0102_0410_8000_0000;
   localparam logic [63:0] ETAB = 64'h0000_0000_0008_1040;
   localparam logic [39:0] CTAB = 40'h01_1020_4080;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   module_fault_s mod_fault_i = '0;
   channel_fault_s [1:0] ch_fault_i = '0;
   record_req_s req_i;
   record_rsp_s rsp_o;
   logic [7:0] flags;
   logic [31:0] stamp;
   logic [31:0] rdat;
   logic [31:0] us0;
   logic [7:0] e;
   logic hit;
   logic late;
   time trel;
   int fails = 0;
   int checks_done = 0;
   always #2.5 clk_i = ~clk_i;
   // Short microsecond so the ticker moves within a short run
   diagnostic_record_bank #(.NUM_CH(2), .CYCLES_PER_US(CPU)) diagnostic_record_bank_i (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .mod_fault_i(mod_fault_i), .ch_fault_i(ch_fault_i), .req_i(req_i), .rsp_o(rsp_o),
      .module_fault_flags_o(flags), .fault_time_stamp_o(stamp));
   coupler_model coupler_model_i (.clk_i(clk_i), .req_o(req_i), .rsp_i(rsp_o));
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wt
   // One access and a comparison of its answer; a lost answer ends the run
   task automatic rd(input logic wr, input logic [15:0] ix, input logic [7:0] sx, input logic eh,
      input logic [31:0] ed);
      coupler_model_i.access(wr, ix, sx, rdat, hit, late);
      if (late) begin
         fails++;
         finish_test();
      end
      `CHK(hit, eh)
      `CHK(rdat, ed)
   endtask : rd
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // Main sequence: reset contents, module flags, channel bytes, refusals
   initial begin
      wt(5);
      rst_n_i = 1'b1;
      trel = $time;
      for (int s = 2; s < 20; s++) begin
         e = s == 3 ? 8'h15 : s == 6 ? 8'h71 : s == 7 ? 8'h08 : s == 8 ? 8'h02 : 8'h00;
         rd(1'b0, `DR_OBJECT_INDEX, 8'(s), s != 18, {24'h0, e});
      end
      $display("test reset_values done");
      for (int i = 0; i < 8; i++) begin
         mod_fault_i = 8'h80 >> i;
         us0 = 32'(($time - trel) / 20);
         wt(4);
         `CHK(flags, MTAB[63-8*i -: 8])
         `CHK(stamp - us0 + 32'h1 <= 32'h3, 1'b1)
         rd(1'b0, `DR_OBJECT_INDEX, 8'h02, 1'b1, {24'h0, MTAB[63-8*i -: 8]});
         rd(1'b0, `DR_OBJECT_INDEX, 8'h05, 1'b1, {24'h0, ETAB[63-8*i -: 8]});
         mod_fault_i = '0;
         wt(4);
      end
      $display("test module_flags done");
      for (int c = 0; c < 2; c++) begin
         for (int j = 0; j < 5; j++) begin
            ch_fault_i[c] = 5'h10 >> j;
            wt(4);
            `CHK(flags, 8'h08)
            rd(1'b0, `DR_OBJECT_INDEX, 8'h0A + 8'(c), 1'b1, {24'h0, CTAB[39-8*j -: 8]});
            rd(1'b0, `DR_OBJECT_INDEX, 8'h09, 1'b1, 32'h1 << c);
            ch_fault_i = '0;
            wt(4);
         end
      end
      $display("test channel_faults done");
      rd(1'b1, `DR_OBJECT_INDEX, 8'h08, 1'b0, 32'h0);
      rd(1'b0, 16'h5004, 8'h02, 1'b0, 32'h0);
      rd(1'b0, `DR_OBJECT_INDEX, 8'h08, 1'b1, 32'h2);
      $display("test refusals done");
      finish_test();
   end
endmodule : diagnostic_record_bank_bench
